// [include/tcr_pkg.sv]
// Package: constants, types and register map of the timer compare/capture/reload block
package tcr_pkg;
    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int TCR_UNITS = 4;
    localparam logic [2:0] TCR_MC_LEN = 3'h6; // Oscillator periods per machine cycle
    localparam logic [15:0] TCR_CNT_MAX = 16'hFFFF;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] TCR_OFF_CTRL = 8'h00;
    localparam logic [7:0] TCR_OFF_UMODE = 8'h04;
    localparam logic [7:0] TCR_OFF_COUNT = 8'h08;
    localparam logic [7:0] TCR_OFF_UNIT0 = 8'h0C; // Reload/capture register, then units 1-3
    localparam logic [7:0] TCR_UNIT_STRIDE = 8'h04;
    localparam logic [7:0] TCR_OFF_PORT = 8'h1C;
    localparam logic [7:0] TCR_OFF_STAT = 8'h20;
    localparam logic [7:0] TCR_OFF_CLR = 8'h24;
    localparam logic [7:0] TCR_OFF_IEN = 8'h28;
    localparam logic [1:0] TCR_RESP_OK = 2'h0;
    localparam logic [1:0] TCR_RESP_ERR = 2'h2;
    // ----------------------------------------
    // Modes
    // ----------------------------------------
    typedef enum logic [1:0] {TCR_STOP, TCR_TIMER, TCR_GATED, TCR_EVENT} tcr_in_mode_t;
    typedef enum logic [1:0] {TCR_RLD_OFF, TCR_RLD_OVF, TCR_RLD_EXT, TCR_RLD_RSV} tcr_rld_t;
    typedef enum logic [1:0] {TCR_U_OFF, TCR_U_CMP, TCR_U_CAP, TCR_U_RSV} tcr_umode_t;
    // ----------------------------------------
    // Register layouts (LSB last)
    // ----------------------------------------
    typedef struct packed {
        logic cmp_mode1;       // Bit 8: compare mode 1
        logic cap_sw;          // Bit 7: capture mode 1 (software)
        logic edge_fall;       // Bit 6: reload register captures on falling edge
        logic ext_en;          // Bit 5: external reload flag enable
        tcr_rld_t rld;         // Bits 4:3
        logic presc12;         // Bit 2: divide by 12 instead of 6
        tcr_in_mode_t in_mode; // Bits 1:0
    } tcr_ctrl_t;
    localparam int TCR_CTRL_W = $bits(tcr_ctrl_t);
    typedef struct packed {
        logic [TCR_UNITS-1:0] cap;   // Bits 9:6 pin captures
        logic [TCR_UNITS-1:0] match; // Bits 5:2 compare matches
        logic ext;                   // Bit 1 external reload flag
        logic ovf;                   // Bit 0 counter overflow flag
    } tcr_stat_t;
    localparam int TCR_STAT_W = $bits(tcr_stat_t);
    // ----------------------------------------
    // Whole state of the block
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] cnt;
        logic [2:0] mc;
        logic half;
        logic chg;
        logic t2_s;
        logic t2_p;
        logic ex_s;
        logic ex_p;
        logic [TCR_UNITS-1:0] cap_s;
        logic [TCR_UNITS-1:0] cap_p;
        tcr_ctrl_t ctrl;
        tcr_umode_t [TCR_UNITS-1:0] um;
        logic [TCR_UNITS-1:0][15:0] cc;
        logic [TCR_UNITS-1:0] port;
        logic [TCR_UNITS-1:0] shadow;
        logic [TCR_UNITS-1:0] swcap;
        tcr_stat_t st;
        tcr_stat_t en;
        logic aw_v;
        logic w_v;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } tcr_state_t;
endpackage

// [verilog/tcr_timer.sv]
// Module: timer with compare, capture and reload, AXI4-Lite register slave
`timescale 1ns/100ps
module tcr_timer
    import tcr_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // AXI4-Lite write channels
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // AXI4-Lite read channels
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [7:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // Port pins
    input wire logic count_gate_input_pin_in,
    input wire logic reload_trigger_pin_in,
    input wire logic [TCR_UNITS-1:0] capture_pin_in,
    output logic [TCR_UNITS-1:0] compare_pin_out,
    // Interrupt
    output logic irq_out
);
    tcr_state_t q;
    tcr_state_t d;
    logic mcs;
    logic tick;
    logic ovf;
    logic ext_ev;
    logic cnt_wr;
    logic wr_go;
    logic [TCR_UNITS-1:0] match;
    logic [TCR_UNITS-1:0] hwcap;
    logic [TCR_UNITS-1:0] port_wr;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] ws);
        logic [15:0] r;
        r[7:0] = ws[0] ? wd[7:0] : old[7:0];
        r[15:8] = ws[1] ? wd[15:8] : old[15:8];
        return r;
    endfunction

    // Byte address of a compare/capture unit
    function automatic logic [7:0] unit_addr(input int i);
        return TCR_OFF_UNIT0 + TCR_UNIT_STRIDE * 8'(i);
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        d = q;
        // Machine-cycle strobe and pin sampling once per machine cycle
        mcs = (q.mc == TCR_MC_LEN - 3'h1);
        d.mc = mcs ? 3'h0 : q.mc + 3'h1;
        d.chg = 1'b0;
        d.swcap = '0;
        if (mcs) begin
            d.half = ~q.half;
            d.t2_s = count_gate_input_pin_in;
            d.t2_p = q.t2_s;
            d.ex_s = reload_trigger_pin_in;
            d.ex_p = q.ex_s;
            d.cap_s = capture_pin_in;
            d.cap_p = q.cap_s;
        end
        // Count enable by input mode
        unique case (q.ctrl.in_mode)
            TCR_TIMER: tick = mcs & (~q.ctrl.presc12 | q.half);
            TCR_GATED: tick = mcs & (~q.ctrl.presc12 | q.half) & q.t2_s;
            TCR_EVENT: tick = mcs & q.t2_p & ~q.t2_s;
            default: tick = 1'b0;
        endcase
        ovf = tick & (q.cnt == TCR_CNT_MAX);
        ext_ev = mcs & q.ex_p & ~q.ex_s;
        // Counter: increment, then reloads, then software write on top
        if (tick) begin
            d.cnt = q.cnt + 16'h0001;
            d.chg = 1'b1;
            if (ovf && q.ctrl.rld == TCR_RLD_OVF) begin
                d.cnt = q.cc[0];
            end
        end
        if (ext_ev && q.ctrl.rld == TCR_RLD_EXT) begin
            d.cnt = q.cc[0];
            d.chg = 1'b1;
        end
        // AXI4-Lite address/data capture, either order
        if (s_axi_awvalid_in && !q.aw_v) begin
            d.aw_v = 1'b1;
            d.awa = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !q.w_v) begin
            d.w_v = 1'b1;
            d.wd = s_axi_wdata_in;
            d.ws = s_axi_wstrb_in;
        end
        if (s_axi_bready_in && q.bv) begin
            d.bv = 1'b0;
        end
        wr_go = q.aw_v & q.w_v & ~q.bv;
        cnt_wr = 1'b0;
        port_wr = '0;
        if (wr_go) begin
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.bv = 1'b1;
            d.br = TCR_RESP_OK;
            unique case (q.awa)
                TCR_OFF_CTRL: d.ctrl = tcr_ctrl_t'(q.wd[TCR_CTRL_W-1:0]);
                TCR_OFF_UMODE: for (int i = 0; i < TCR_UNITS; i++) begin
                    d.um[i] = tcr_umode_t'(q.wd[2*i +: 2]); // Enum fields need a cast each
                end
                TCR_OFF_COUNT: begin
                    cnt_wr = 1'b1;
                    d.cnt = merge16(q.cnt, q.wd, q.ws);
                end
                TCR_OFF_PORT: port_wr = {TCR_UNITS{1'b1}}; // One write reaches every latch
                TCR_OFF_CLR: d.st = q.st & ~tcr_stat_t'(q.wd[TCR_STAT_W-1:0]);
                TCR_OFF_IEN: d.en = tcr_stat_t'(q.wd[TCR_STAT_W-1:0]);
                TCR_OFF_STAT: d.br = TCR_RESP_OK;
                default: begin
                    d.br = TCR_RESP_ERR;
                    for (int i = 0; i < TCR_UNITS; i++) begin
                        if (q.awa == unit_addr(i)) begin
                            d.br = TCR_RESP_OK;
                            d.cc[i] = merge16(q.cc[i], q.wd, q.ws);
                            // Low-byte write arms a software capture
                            d.swcap[i] = (q.um[i] == TCR_U_CAP) & q.ctrl.cap_sw & q.ws[0];
                        end
                    end
                end
            endcase
        end
        // Compare units and port latches
        for (int i = 0; i < TCR_UNITS; i++) begin
            match[i] = q.chg & (q.um[i] == TCR_U_CMP) & (q.cnt == q.cc[i]);
            if (port_wr[i]) begin
                if (q.um[i] != TCR_U_CMP) begin
                    d.port[i] = q.wd[i];
                end else if (q.ctrl.cmp_mode1) begin
                    d.shadow[i] = q.wd[i];
                end
                // Compare mode 0 drops the write: pin belongs to the timer
            end
            if (q.um[i] == TCR_U_CMP && !q.ctrl.cmp_mode1) begin
                if (match[i]) begin
                    d.port[i] = 1'b1;
                end
                if (ovf) begin
                    d.port[i] = 1'b0;
                end
            end else if (match[i]) begin
                d.port[i] = q.shadow[i];
            end
        end
        // Captures: pin edges in mode 0, delayed software strobe in mode 1
        for (int i = 0; i < TCR_UNITS; i++) begin
            if (i == 0) begin
                hwcap[i] = q.ctrl.edge_fall ? (q.cap_p[i] & ~q.cap_s[i])
                                            : (~q.cap_p[i] & q.cap_s[i]);
            end else begin
                hwcap[i] = ~q.cap_p[i] & q.cap_s[i];
            end
            hwcap[i] = hwcap[i] & mcs & (q.um[i] == TCR_U_CAP) & ~q.ctrl.cap_sw;
            if (hwcap[i] || q.swcap[i]) begin
                d.cc[i] = q.cnt;
            end
        end
        // Sticky status; a set in the clear cycle survives
        d.st.ovf = d.st.ovf | ovf;
        d.st.ext = d.st.ext | (ext_ev & q.ctrl.ext_en);
        d.st.match = d.st.match | match;
        d.st.cap = d.st.cap | hwcap;
        // Read channel
        if (s_axi_rready_in && q.rv) begin
            d.rv = 1'b0;
        end
        if (s_axi_arvalid_in && !q.rv) begin
            d.rv = 1'b1;
            d.rr = TCR_RESP_OK;
            d.rd = '0;
            unique case (s_axi_araddr_in)
                TCR_OFF_CTRL: d.rd[TCR_CTRL_W-1:0] = q.ctrl;
                TCR_OFF_UMODE: d.rd[2*TCR_UNITS-1:0] = q.um;
                TCR_OFF_COUNT: d.rd[15:0] = q.cnt;
                TCR_OFF_PORT: d.rd[TCR_UNITS-1:0] = q.port;
                TCR_OFF_STAT: d.rd[TCR_STAT_W-1:0] = q.st;
                TCR_OFF_CLR: d.rd = '0;
                TCR_OFF_IEN: d.rd[TCR_STAT_W-1:0] = q.en;
                default: begin
                    d.rr = TCR_RESP_ERR;
                    for (int i = 0; i < TCR_UNITS; i++) begin
                        if (s_axi_araddr_in == unit_addr(i)) begin
                            d.rr = TCR_RESP_OK;
                            d.rd[15:0] = q.cc[i];
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Ready terms and irq_out are combinational; everything else is a flop
    assign s_axi_awready_out = ~q.aw_v;
    assign s_axi_wready_out = ~q.w_v;
    assign s_axi_bvalid_out = q.bv;
    assign s_axi_bresp_out = q.br;
    assign s_axi_arready_out = ~q.rv;
    assign s_axi_rvalid_out = q.rv;
    assign s_axi_rdata_out = q.rd;
    assign s_axi_rresp_out = q.rr;
    assign compare_pin_out = q.port;
    assign irq_out = |(q.st & q.en);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    a_ovf_sets_flag: assert property (ovf |=> q.st.ovf)
        else $error("overflow did not set flag");
    a_timer_rate: assert property
        (tick && q.ctrl.presc12 && q.ctrl.in_mode != TCR_EVENT |-> q.half && mcs)
        else $error("divide by 12 ticked off phase");
    a_gate_low_stops: assert property
        (q.ctrl.in_mode == TCR_GATED && !q.t2_s |-> !tick)
        else $error("gated timer counted with gate low");
    a_event_edge: assert property
        (q.ctrl.in_mode == TCR_EVENT && tick |-> q.t2_p && !q.t2_s && mcs)
        else $error("event count without falling edge");
    a_reload_ovf: assert property
        (ovf && q.ctrl.rld == TCR_RLD_OVF && !cnt_wr |=> q.cnt == $past(q.cc[0]))
        else $error("rollover reload missing");
    a_reload_ext: assert property
        (ext_ev && q.ctrl.rld == TCR_RLD_EXT && !cnt_wr |=> q.cnt == $past(q.cc[0]))
        else $error("external reload missing");
    a_ext_flag: assert property
        (ext_ev && q.ctrl.ext_en |=> q.st.ext)
        else $error("external flag not set");
    a_ext_flag_off: assert property
        (!q.st.ext && !(ext_ev && q.ctrl.ext_en) |=> !q.st.ext)
        else $error("external flag set while disabled");
    a_cmp0_high: assert property
        (match[1] && !ovf && !q.ctrl.cmp_mode1 |=> compare_pin_out[1])
        else $error("compare mode 0 match left pin low");
    a_cmp0_ignore: assert property
        (port_wr[1] && q.um[1] == TCR_U_CMP && !q.ctrl.cmp_mode1 && !match[1] && !ovf
         |=> $stable(compare_pin_out[1]))
        else $error("compare mode 0 took a port write");
    a_cmp1_shadow: assert property
        (match[2] && q.ctrl.cmp_mode1 |=> compare_pin_out[2] == $past(q.shadow[2]))
        else $error("shadow not copied on match");
    a_sw_capture: assert property
        (wr_go && q.awa == TCR_OFF_UNIT0 && q.ws[0] && q.um[0] == TCR_U_CAP
         && q.ctrl.cap_sw ##1 1'b1 |=> q.cc[0] == $past(q.cnt))
        else $error("software capture not taken next cycle");
    a_sw_no_irq: assert property
        (q.swcap[3] && !q.st.cap[3] |=> !q.st.cap[3])
        else $error("software capture raised a flag");
    a_wr_wins: assert property (cnt_wr && q.ws == 4'hF |=> q.cnt == $past(q.wd[15:0]))
        else $error("counter write lost to reload");
endmodule

// [tb/tcr_pins.sv]
// Pin-side model: sources for the gate/event, reload trigger and capture pins
`timescale 1ns/100ps
module tcr_pins (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Levels asked for by the bench
    input wire logic gate_want_in,
    input wire logic trig_want_in,
    input wire logic [3:0] cap_want_in,
    // Pin levels
    output logic gate_pin_out,
    output logic trig_pin_out,
    output logic [3:0] cap_pin_out
);
    // ----------------------------------------
    // Level hold
    // ----------------------------------------
    logic [3:0] held_q;
    // Levels move only after 12 clocks, so each level meets two samples
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            held_q <= 4'h0;
            gate_pin_out <= 1'b0;
            trig_pin_out <= 1'b0;
            cap_pin_out <= 4'h0;
        end else if (held_q < 4'hB) begin
            held_q <= held_q + 4'h1;
        end else if ({gate_want_in, trig_want_in, cap_want_in} !=
                     {gate_pin_out, trig_pin_out, cap_pin_out}) begin
            held_q <= 4'h0;
            gate_pin_out <= gate_want_in;
            trig_pin_out <= trig_want_in;
            cap_pin_out <= cap_want_in;
        end
    end
endmodule

// [tb/tb_timer2_compare_capture_reload.sv]
// Self-checking bench of the timer compare/capture/reload block
`timescale 1ns/100ps
module tb_timer2_compare_capture_reload
    import tcr_pkg::*;
();
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [7:0] A_U1 = TCR_OFF_UNIT0 + TCR_UNIT_STRIDE;
    localparam logic [7:0] A_U2 = A_U1 + TCR_UNIT_STRIDE;
    localparam logic [7:0] A_U3 = A_U2 + TCR_UNIT_STRIDE;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'h0;
    logic gate_w = 1'b0, trig_w = 1'b0;
    logic [3:0] cap_w = 4'h0;
    logic awr, wrr, bv, arr, rv, irq, gate_p, trig_p;
    logic [1:0] br, rr;
    logic [31:0] rd_w;
    logic [3:0] cap_p, cmp_p;
    int n_errors = 0, checks_done = 0, cyc = 0;
    logic [31:0] q_d[$];
    logic [1:0] q_r[$];
    // Clock of 25 ns
    initial forever #12.5 mclk_in = ~mclk_in;
    tcr_timer dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
        .s_axi_bresp_out(br), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
        .s_axi_rdata_out(rd_w), .s_axi_rresp_out(rr),
        .count_gate_input_pin_in(gate_p), .reload_trigger_pin_in(trig_p),
        .capture_pin_in(cap_p), .compare_pin_out(cmp_p), .irq_out(irq));
    tcr_pins pins_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .gate_want_in(gate_w), .trig_want_in(trig_w), .cap_want_in(cap_w),
        .gate_pin_out(gate_p), .trig_pin_out(trig_p), .cap_pin_out(cap_p));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF, input logic [1:0] er = TCR_RESP_OK);
        logic got;
        got = 1'b0;
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        ws <= s;
        bre <= 1'b1;
        while (!got) begin
            @(posedge mclk_in);
            if (awr === 1'b1) awv <= 1'b0;
            if (wrr === 1'b1) wv <= 1'b0;
            got = (bv === 1'b1);
        end
        cmp("bresp", {30'h0, er}, {30'h0, br});
        bre <= 1'b0;
        @(posedge mclk_in);
    endtask
    // Read: the expected answer is noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = TCR_RESP_OK);
        logic got;
        got = 1'b0;
        q_d.push_back(d);
        q_r.push_back(er);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        while (!got) begin
            @(posedge mclk_in);
            if (arr === 1'b1) arv <= 1'b0;
            got = (rv === 1'b1);
        end
        rre <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    // Both control writes have equal latency, so the counter runs exactly n clocks
    task automatic run(input logic [31:0] on, input logic [31:0] off, input int n);
        int t0;
        t0 = cyc;
        wr(TCR_OFF_CTRL, on);
        while (cyc < t0 + n) @(posedge mclk_in);
        wr(TCR_OFF_CTRL, off);
    endtask
    // Monitor: oldest note against each accepted read answer
    always @(posedge mclk_in) begin
        if (rv === 1'b1 && rre === 1'b1) begin
            if (q_d.size() == 0) begin
                n_errors++;
                $display("Error read note expected 1 seen 0");
            end else begin
                cmp("rdata", q_d.pop_front(), rd_w);
                cmp("rresp", {30'h0, q_r.pop_front()}, {30'h0, rr});
            end
        end
    end
    // Cycle count; the ceiling cuts a hang short
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            $display("Error timeout expected 0 seen %0d", cyc);
            test_done();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [15:0] r;
        void'($urandom(32'h45C2));
        repeat (3) @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        rd(TCR_OFF_CTRL, 32'h0);
        rd(TCR_OFF_COUNT, 32'h0);
        rd(TCR_OFF_STAT, 32'h0);
        rd(TCR_OFF_IEN, 32'h0);
        rd(8'h40, 32'h0, TCR_RESP_ERR);
        wr(8'h40, 32'h1, 4'hF, TCR_RESP_ERR);
        cmp("compare pins", 32'h0, {28'h0, cmp_p});
        $display("Test reset done");
        // Sixty clocks at /6 and 120 at /12 both make ten counts
        run(32'h1, 32'h0, 60);
        rd(TCR_OFF_COUNT, 32'hA);
        wr(TCR_OFF_COUNT, 32'h0);
        run(32'h5, 32'h0, 120);
        rd(TCR_OFF_COUNT, 32'hA);
        wr(TCR_OFF_COUNT, 32'h0);
        run(32'h2, 32'h0, 60);
        rd(TCR_OFF_COUNT, 32'h0);
        gate_w <= 1'b1;
        hold(36);
        run(32'h2, 32'h0, 60);
        rd(TCR_OFF_COUNT, 32'hA);
        wr(TCR_OFF_COUNT, 32'h0);
        wr(TCR_OFF_CTRL, 32'h3);
        repeat (3) begin
            gate_w <= 1'b0;
            hold(36);
            gate_w <= 1'b1;
            hold(36);
        end
        wr(TCR_OFF_CTRL, 32'h0);
        rd(TCR_OFF_COUNT, 32'h3);
        $display("Test count modes done");
        // Rollover from FFFE: FFFF, reload 1234, then three more counts
        wr(TCR_OFF_UNIT0, 32'h1234);
        wr(TCR_OFF_COUNT, 32'hFFFE);
        run(32'h9, 32'h8, 30);
        rd(TCR_OFF_COUNT, 32'h1237);
        rd(TCR_OFF_STAT, 32'h1);
        cmp("irq masked", 32'h0, {31'h0, irq});
        wr(TCR_OFF_IEN, 32'h1);
        cmp("irq enabled", 32'h1, {31'h0, irq});
        wr(TCR_OFF_CLR, 32'h1);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        rd(TCR_OFF_STAT, 32'h0);
        // Trigger falls with the flag enabled, then disabled
        wr(TCR_OFF_UNIT0, 32'hABCD);
        for (int k = 0; k < 2; k++) begin
            wr(TCR_OFF_CLR, 32'h3FF);
            wr(TCR_OFF_COUNT, 32'h5);
            wr(TCR_OFF_CTRL, k == 0 ? 32'h30 : 32'h10);
            trig_w <= 1'b1;
            hold(36);
            trig_w <= 1'b0;
            hold(36);
            rd(TCR_OFF_COUNT, 32'hABCD);
            rd(TCR_OFF_STAT, k == 0 ? 32'h2 : 32'h0);
        end
        $display("Test reload done");
        // Compare mode 0 on unit 1 at value 3
        wr(TCR_OFF_CLR, 32'h3FF);
        wr(A_U1, 32'h3);
        wr(TCR_OFF_COUNT, 32'h0);
        wr(TCR_OFF_UMODE, 32'h4);
        run(32'h1, 32'h0, 48);
        cmp("compare pins", 32'h2, {28'h0, cmp_p});
        wr(TCR_OFF_PORT, 32'h0);
        cmp("compare pins", 32'h2, {28'h0, cmp_p});
        rd(TCR_OFF_STAT, 32'h8);
        wr(TCR_OFF_IEN, 32'h8);
        cmp("irq match", 32'h1, {31'h0, irq});
        wr(TCR_OFF_IEN, 32'h0);
        wr(TCR_OFF_COUNT, 32'hFFFF);
        run(32'h1, 32'h0, 12);
        cmp("compare pins", 32'h0, {28'h0, cmp_p});
        // Compare mode 1 on unit 2; unit 1 now plain port
        wr(A_U2, 32'h5);
        wr(TCR_OFF_UMODE, 32'h10);
        wr(TCR_OFF_CTRL, 32'h100);
        wr(TCR_OFF_COUNT, 32'h0);
        wr(TCR_OFF_PORT, 32'h6);
        cmp("compare pins", 32'h2, {28'h0, cmp_p});
        run(32'h101, 32'h100, 48);
        cmp("compare pins", 32'h6, {28'h0, cmp_p});
        $display("Test compare done");
        // Pin captures on unit 3 (rising) and unit 0 (falling chosen)
        wr(TCR_OFF_CLR, 32'h3FF);
        wr(TCR_OFF_UMODE, 32'h82);
        wr(TCR_OFF_CTRL, 32'h0);
        r = 16'($urandom());
        wr(TCR_OFF_COUNT, {16'h0, r});
        cap_w <= 4'h8;
        hold(36);
        rd(A_U3, {16'h0, r});
        rd(TCR_OFF_STAT, 32'h200);
        wr(TCR_OFF_CLR, 32'h3FF);
        wr(TCR_OFF_CTRL, 32'h40);
        r = 16'($urandom());
        wr(TCR_OFF_COUNT, {16'h0, r});
        cap_w <= 4'h9;
        hold(36);
        rd(TCR_OFF_UNIT0, 32'hABCD);
        cap_w <= 4'h8;
        hold(36);
        rd(TCR_OFF_UNIT0, {16'h0, r});
        rd(TCR_OFF_STAT, 32'h40);
        // Software capture by a low-byte write
        wr(TCR_OFF_CLR, 32'h3FF);
        wr(TCR_OFF_CTRL, 32'h80);
        r = 16'($urandom());
        wr(TCR_OFF_COUNT, {16'h0, r});
        wr(A_U3, 32'h55, 4'h1);
        rd(A_U3, {16'h0, r});
        // Same on the reload register, still in capture mode
        wr(TCR_OFF_UNIT0, 32'h66, 4'h1);
        rd(TCR_OFF_UNIT0, {16'h0, r});
        rd(TCR_OFF_STAT, 32'h0);
        $display("Test capture done");
        test_done();
    end
endmodule
